// ---- logic/pcc_pkg.sv ----
// Constants and carrier types for the compensation and phase configuration bank.
// Assumes a command decoder on the same clock that presents one command per request.
package pcc_pkg;

    // Command codes answered by this bank
    localparam logic [7:0] PCC_CMD_COMP     = 8'hd3; // Loop compensation, per page
    localparam logic [7:0] PCC_CMD_CONFIG   = 8'hf5; // Phase and sense, device-wide
    localparam logic [7:0] PCC_PAGE_ALL     = 8'hff; // Page value that addresses both channels

    // Reset values
    localparam logic [7:0] PCC_COMP_RESET   = 8'h70;
    localparam logic [7:0] PCC_CONFIG_RESET = 8'h10;

    // Field positions of the phase and sense setting
    localparam int PCC_FB_SHARE_BIT = 7;
    localparam int PCC_GAIN_MSB     = 6;
    localparam int PCC_GAIN_LSB     = 5;
    localparam int PCC_CLK_GATE_BIT = 4;
    localparam int PCC_PHASE_MSB    = 2;
    localparam int PCC_PHASE_LSB    = 0;
    localparam logic [2:0] PCC_PHASE_MAX = 3'h4; // Highest defined phase code

    // Field positions of the loop compensation setting
    localparam int PCC_GM_MSB   = 7;
    localparam int PCC_GM_LSB   = 5;
    localparam int PCC_RES_MSB  = 4;
    localparam int PCC_RES_LSB  = 0;

    // Data bytes carried by every access
    localparam logic [1:0] PCC_BYTE_COUNT = 2'h1;

    // Shared clock line release state
    typedef enum logic {
        PCC_SC_HOLD     = 1'b0,
        PCC_SC_RELEASED = 1'b1
    } pcc_share_e;

    // One command from the serial front end
    typedef struct packed {
        logic       valid;     // One-cycle request strobe
        logic       write;     // 1 write, 0 read
        logic [7:0] code;      // Command code
        logic [7:0] page;      // Current page
        logic [1:0] byteCount; // Data bytes the host sent
        logic [7:0] data;      // Write data
    } pcc_cmd_s;

    // Answer to one command
    typedef struct packed {
        logic       ack;       // Accepted
        logic       nack;      // Refused
        logic       busyFault; // Refused because a channel runs
        logic [7:0] rdData;    // Read byte, valid with ack on a read
    } pcc_rsp_s;

    // Decoded loop values: gm in uS, resistor in 10 ohm steps
    typedef struct packed {
        logic [12:0] gm;
        logic [12:0] res;
    } pcc_loop_s;

endpackage

// ---- logic/pcc_comp_decode.sv ----
// Lookup of the loop compensation byte into amplifier gm and resistor value.
// Purely combinational; the caller registers the result.
`timescale 1ns/1ps
`default_nettype none
module pcc_comp_decode
    import pcc_pkg::*;
(
    input  wire logic [7:0] comp,
    output var pcc_loop_s   loop
);

    // Amplifier gm in uS for each 3-bit code, eight steps
    function automatic logic [12:0] gmOf(input logic [2:0] code);
        logic [12:0] tbl [8];
        tbl = '{13'h3e8, 13'h690, 13'h92e, 13'hbcc, 13'he6a, 13'h1108, 13'h13b0, 13'h1662};
        return tbl[code];
    endfunction

    // Resistor in 10 ohm units for each 5-bit code; steps widen with the code
    function automatic logic [12:0] resOf(input logic [4:0] code);
        logic [12:0] tbl [32];
        tbl = '{13'h0, 13'h19, 13'h32, 13'h4b, 13'h64, 13'h7d, 13'h96, 13'haf,
                13'hc8, 13'hfa, 13'h12c, 13'h15e, 13'h190, 13'h1c2, 13'h1f4, 13'h226,
                13'h258, 13'h2bc, 13'h320, 13'h384, 13'h44c, 13'h514, 13'h5dc, 13'h6a4,
                13'h7d0, 13'h960, 13'haf0, 13'hc80, 13'hed8, 13'h11f8, 13'h1518, 13'h1838};
        return tbl[code];
    endfunction

    // Both fields decode independently
    always_comb begin
        loop.gm  = gmOf(comp[PCC_GM_MSB:PCC_GM_LSB]);
        loop.res = resOf(comp[PCC_RES_MSB:PCC_RES_LSB]);
    end

endmodule
`default_nettype wire

// ---- logic/pcc_pwm_config.sv ----
// Loop compensation and phase/sense configuration bank with its derived controls.
// Assumes commands arrive decoded on clk_sys; run pins and sync pin are asynchronous.
// What this block does
// - Bits 7..5 of compensation select amplifier gm
// - Bits 4..0 select internal compensation resistor
// - Every access carries exactly one data byte; only writes check the count, reads ignore it
// - Phase offset referenced to sync falling edge
// - Phase setting writable only while powered off
// - Phase write while running: refuse, busy fault, keep
// - Bit 7 makes channel 1 use channel 0 feedback
// - Bits 6..5 pick sense gain 2x/4x/8x
// - Gating on: hold clock low until start threshold
// - Gating on: pull clock low below stop threshold
// - Bits 2..0 pick the two channel phases
// - Phase setting device-wide, resets to 10h
// - Compensation per page, nonvolatile, resets to 70h
`timescale 1ns/1ps
`default_nettype none
module pcc_pwm_config
    import pcc_pkg::*;
(
    input  wire logic       clk_sys,
    input  wire logic       rst,
    input  wire pcc_cmd_s   cmd,          // Command from the serial front end
    output var pcc_rsp_s    rsp,          // Registered answer
    input  wire logic       run0Pin,      // Run pin of channel 0, asynchronous
    input  wire logic       run1Pin,      // Run pin of channel 1, asynchronous
    input  wire logic       cmdOn0,       // Channel 0 commanded on
    input  wire logic       cmdOn1,       // Channel 1 commanded on
    input  wire logic       syncPin,      // External sync, asynchronous
    input  wire logic       vinApplied,   // Input supply present
    input  wire logic       vinAboveOn,   // Supply above input_start_threshold
    input  wire logic       vinBelowOff,  // Supply below input_stop_threshold
    input  wire logic       nvmLoad,      // Restore stored compensation
    input  wire logic [7:0] nvmComp0,     // Stored compensation, page 0
    input  wire logic [7:0] nvmComp1,     // Stored compensation, page 1
    output logic [7:0]      comp0,        // Compensation byte, page 0, for storage
    output logic [7:0]      comp1,        // Compensation byte, page 1, for storage
    output var pcc_loop_s   loop0,        // Decoded loop values, channel 0
    output var pcc_loop_s   loop1,        // Decoded loop values, channel 1
    output logic            fbShare,      // Channel 1 uses channel 0 feedback
    output logic [3:0]      senseGain,    // Gain factor 2, 4 or 8; 0 for reserved
    output logic [8:0]      phase0,       // Channel 0 phase in degrees
    output logic [8:0]      phase1,       // Channel 1 phase in degrees
    output logic            syncRef,      // Pulse on sync falling edge
    output logic            shareClkO,    // Shared clock line drive level, always low
    output logic            shareClkOe    // High while the line is pulled low
);

    logic [2:0]  syncMeta;      // First stage: sync, run1, run0
    logic [2:0]  syncPins;      // Second stage
    logic        syncLast;      // Previous synchronised sync level
    logic [7:0]  cfg;           // Phase and sense setting
    pcc_share_e  shareState;    // Shared clock release state
    pcc_share_e  next_shareState;
    pcc_loop_s   dec0;          // Combinational lookups
    pcc_loop_s   dec1;
    logic        running;       // Any run pin high and any channel commanded on
    logic        isWrite;
    logic        countOk;

    // Running if either run pin is high and either channel is commanded on, pins and commands not paired per channel
    assign running = (syncPins[0] | syncPins[1]) & (cmdOn0 | cmdOn1);
    assign isWrite = cmd.valid & cmd.write;
    assign countOk = (cmd.byteCount == PCC_BYTE_COUNT);

    // Two-flop synchronisers for the asynchronous pins
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            syncMeta <= 3'h0;
            syncPins <= 3'h0;
            syncLast <= 1'b0;
        end else begin
            syncMeta <= {syncPin, run1Pin, run0Pin};
            syncPins <= syncMeta;
            syncLast <= syncPins[2];
        end
    end

    // Phase reference: falling edge only, rising edge ignored
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            syncRef <= 1'b0;
        end else begin
            syncRef <= syncLast & ~syncPins[2];
        end
    end

    // Per-page compensation storage; page ff writes both
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            comp0 <= PCC_COMP_RESET;
            comp1 <= PCC_COMP_RESET;
        end else if (nvmLoad) begin
            // Restore wins over a host write in the same cycle
            comp0 <= nvmComp0;
            comp1 <= nvmComp1;
        end else if (isWrite && cmd.code == PCC_CMD_COMP && countOk) begin
            if (cmd.page == 8'h00 || cmd.page == PCC_PAGE_ALL) begin
                comp0 <= cmd.data;
            end
            if (cmd.page == 8'h01 || cmd.page == PCC_PAGE_ALL) begin
                comp1 <= cmd.data;
            end
        end
    end

    // Device-wide phase and sense setting, locked while running
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            cfg <= PCC_CONFIG_RESET;
        end else if (isWrite && cmd.code == PCC_CMD_CONFIG && countOk && !running) begin
            cfg <= cmd.data;
        end
    end

    // Answer one cycle after the request
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            rsp <= '0;
        end else begin
            rsp <= '0;
            if (cmd.valid) begin
                if (cmd.code != PCC_CMD_COMP && cmd.code != PCC_CMD_CONFIG) begin
                    // Unknown code to this bank
                    rsp.nack <= 1'b1;
                end else if (!cmd.write) begin
                    // Read returns exactly one byte
                    rsp.ack <= 1'b1;
                    if (cmd.code == PCC_CMD_CONFIG) begin
                        rsp.rdData <= cfg;
                    end else begin
                        rsp.rdData <= (cmd.page == 8'h01) ? comp1 : comp0;
                    end
                end else if (!countOk) begin
                    // Wrong byte count: refused, nothing stored
                    rsp.nack <= 1'b1;
                end else if (cmd.code == PCC_CMD_CONFIG && running) begin
                    rsp.nack      <= 1'b1;
                    rsp.busyFault <= 1'b1;
                end else begin
                    rsp.ack <= 1'b1;
                end
            end
        end
    end

    // Compensation lookups, one per channel
    pcc_comp_decode uDec0 (
        .comp (comp0),
        .loop (dec0)
    );
    pcc_comp_decode uDec1 (
        .comp (comp1),
        .loop (dec1)
    );

    // Register decoded loop values so outputs come from flops
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            loop0 <= '0;
            loop1 <= '0;
        end else begin
            loop0 <= dec0;
            loop1 <= dec1;
        end
    end

    // Gain factor; reserved code is the host's duty to avoid
    function automatic logic [3:0] gainOf(input logic [1:0] code);
        unique case (code)
            2'h0:    return 4'h2;
            2'h1:    return 4'h4;
            2'h2:    return 4'h8;
            default: return 4'h0;
        endcase
    endfunction

    // Feedback sharing and sense gain follow the setting
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            fbShare   <= 1'b0;
            senseGain <= 4'h2;
        end else begin
            fbShare   <= cfg[PCC_FB_SHARE_BIT];
            senseGain <= gainOf(cfg[PCC_GAIN_MSB:PCC_GAIN_LSB]);
        end
    end

    // Phase pair per code; reserved codes hold the last pair
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            phase0 <= 9'h0;
            phase1 <= 9'hb4;
        end else begin
            unique case (cfg[PCC_PHASE_MSB:PCC_PHASE_LSB])
                3'h0: begin
                    phase0 <= 9'h0;
                    phase1 <= 9'hb4;
                end
                3'h1: begin
                    phase0 <= 9'h5a;
                    phase1 <= 9'h10e;
                end
                3'h2: begin
                    phase0 <= 9'h0;
                    phase1 <= 9'hf0;
                end
                3'h3: begin
                    phase0 <= 9'h0;
                    phase1 <= 9'h78;
                end
                3'h4: begin
                    phase0 <= 9'h78;
                    phase1 <= 9'hf0;
                end
                default: begin
                    phase0 <= phase0;
                    phase1 <= phase1;
                end
            endcase
        end
    end

    // Shared clock release: gated on thresholds or on supply alone
    always_comb begin
        next_shareState = shareState;
        unique case (shareState)
            PCC_SC_HOLD: begin
                // With gating on, stop level still low blocks release, so a pull request wins; gating off ignores it
                if (cfg[PCC_CLK_GATE_BIT] ? (vinAboveOn && !vinBelowOff) : vinApplied) begin
                    next_shareState = PCC_SC_RELEASED;
                end
            end
            PCC_SC_RELEASED: begin
                if (cfg[PCC_CLK_GATE_BIT] && vinBelowOff) begin
                    next_shareState = PCC_SC_HOLD;
                end
            end
        endcase
    end

    // Open-drain line: drive low only while held
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            shareState <= PCC_SC_HOLD;
            shareClkOe <= 1'b1;
            shareClkO  <= 1'b0;
        end else begin
            shareState <= next_shareState;
            shareClkOe <= (next_shareState == PCC_SC_HOLD);
            shareClkO  <= 1'b0;
        end
    end

    // Checks
    sequence cfgWriteBusy;
        isWrite && cmd.code == PCC_CMD_CONFIG && countOk && running;
    endsequence
    sequence cfgWriteOk;
        isWrite && cmd.code == PCC_CMD_CONFIG && countOk && !running;
    endsequence

    a_busy_refuse: assert property (@(posedge clk_sys) disable iff (rst)
        cfgWriteBusy |=> rsp.nack && rsp.busyFault && !rsp.ack && $stable(cfg))
        else $error("busy write not refused");
    a_cfg_accept: assert property (@(posedge clk_sys) disable iff (rst)
        cfgWriteOk |=> rsp.ack && cfg == $past(cmd.data))
        else $error("idle write not stored");
    a_byte_count: assert property (@(posedge clk_sys) disable iff (rst)
        (isWrite && !countOk) |=> rsp.nack && !rsp.ack)
        else $error("wrong byte count accepted");
    a_fb_share: assert property (@(posedge clk_sys) disable iff (rst)
        cfgWriteOk |=> ##1 fbShare == cfg[PCC_FB_SHARE_BIT])
        else $error("feedback share mismatch");
    a_gain_map: assert property (@(posedge clk_sys) disable iff (rst)
        (cfgWriteOk and (cmd.data[6:5] == 2'h1)) |=> ##1 senseGain == 4'h4)
        else $error("gain 4x not applied");
    a_phase_map: assert property (@(posedge clk_sys) disable iff (rst)
        (cfgWriteOk and (cmd.data[2:0] == 3'h1)) |=> ##1 phase0 == 9'h5a && phase1 == 9'h10e)
        else $error("phase 90/270 not applied");
    a_phase_keep: assert property (@(posedge clk_sys) disable iff (rst)
        (cfgWriteOk and (cmd.data[2:0] > PCC_PHASE_MAX)) |=> ##1 $stable(phase0) && $stable(phase1))
        else $error("reserved phase changed phases");
    a_clk_hold: assert property (@(posedge clk_sys) disable iff (rst)
        (shareState == PCC_SC_HOLD && cfg[PCC_CLK_GATE_BIT] && !vinAboveOn) |=> shareClkOe)
        else $error("clock released before start threshold");
    a_clk_pull: assert property (@(posedge clk_sys) disable iff (rst)
        (cfg[PCC_CLK_GATE_BIT] && vinBelowOff) |=> shareClkOe)
        else $error("clock not pulled below stop threshold");
    a_sync_fall: assert property (@(posedge clk_sys) disable iff (rst)
        $fell(syncPins[2]) |=> syncRef ##1 !syncRef)
        else $error("falling edge reference missed");
    a_clk_release: assert property (@(posedge clk_sys) disable iff (rst)
        (shareState == PCC_SC_HOLD && !cfg[PCC_CLK_GATE_BIT] && vinApplied) |=> !shareClkOe)
        else $error("clock not released with gating off");
    a_nvm_restore: assert property (@(posedge clk_sys) disable iff (rst)
        nvmLoad |=> comp0 == $past(nvmComp0) && comp1 == $past(nvmComp1))
        else $error("stored compensation not restored");

endmodule
`default_nettype wire

// ---- testbench/pcc_host_model.sv ----
// Host-side model: issues configuration commands with any byte count to the bank.
// Assumes the bench calls send from its main process, clocked by clk_sys.
`timescale 1ns/1ps
`default_nettype none
module pcc_host_model
    import pcc_pkg::*;
(
    input  wire logic clk_sys, // System clock
    output var pcc_cmd_s cmd   // Command towards the bank
);
    // Idle at time zero, nothing requested
    initial cmd = '0;

    // One request: launched after a falling edge, held across one rising edge
    task automatic send(input logic wr, input logic [7:0] code, input logic [7:0] page,
                        input logic [1:0] cnt, input logic [7:0] data);
        @(negedge clk_sys);
        cmd <= '{1'b1, wr, code, page, cnt, data};
        @(negedge clk_sys);
        // Released lines show inverted values, so a stale copy cannot pass
        cmd <= '{1'b0, ~wr, ~code, ~page, ~cnt, ~data};
    endtask
endmodule
`default_nettype wire

// ---- testbench/tb_pcc_pwm_config.sv ----
// Self-checking bench for the compensation and phase configuration bank.
// Assumes the host model in pcc_host_model.sv and the package pcc_pkg.
`timescale 1ns/1ps
`default_nettype none
module tb_pcc_pwm_config;
    import pcc_pkg::*;
    logic        clk_sys = 1'b0;    // 100 MHz clock
    logic        rst     = 1'b1;    // Held for 20 cycles
    pcc_cmd_s    cmd;               // From host model
    pcc_rsp_s    rsp;               // Answers to check
    logic        run0Pin = 1'b0, run1Pin = 1'b0, cmdOn0 = 1'b0, cmdOn1 = 1'b0;
    logic        syncPin = 1'b1, nvmLoad = 1'b0;
    logic        vinApplied = 1'b0, vinAboveOn = 1'b0, vinBelowOff = 1'b0;
    logic [7:0]  nvmComp0 = 8'h00, nvmComp1 = 8'h00, comp0, comp1, d;
    pcc_loop_s   loop0, loop1;
    logic        fbShare, syncRef, shareClkO, shareClkOe;
    logic [3:0]  senseGain;
    logic [8:0]  phase0, phase1;
    pcc_rsp_s    expQ[$];           // Expected answers, oldest first
    int          bad_count = 0, checks_done = 0, cycles = 0, syncCount = 0;
    logic [31:0] lfsr = 32'h0001531e; // Fixed seed
    // Expected decodes: gm in uS, resistor in 10 ohm units, phases in degrees
    int gmTab[8]   = '{1000, 1680, 2350, 3020, 3690, 4360, 5040, 5730};
    int resTab[32] = '{0, 25, 50, 75, 100, 125, 150, 175, 200, 250, 300, 350, 400, 450, 500, 550,
                       600, 700, 800, 900, 1100, 1300, 1500, 1700, 2000, 2400, 2800, 3200, 3800,
                       4600, 5400, 6200};
    int ph0Tab[5]  = '{0, 90, 0, 0, 120};
    int ph1Tab[5]  = '{180, 270, 240, 120, 240};
    int gainTab[3] = '{2, 4, 8};

    // Free-running clock
    always #5 clk_sys = ~clk_sys;

    pcc_host_model pcc_host_model_i (.clk_sys(clk_sys), .cmd(cmd));

    pcc_pwm_config pcc_pwm_config_i (
        .clk_sys(clk_sys), .rst(rst), .cmd(cmd), .rsp(rsp), .run0Pin(run0Pin), .run1Pin(run1Pin),
        .cmdOn0(cmdOn0), .cmdOn1(cmdOn1), .syncPin(syncPin), .vinApplied(vinApplied),
        .vinAboveOn(vinAboveOn), .vinBelowOff(vinBelowOff), .nvmLoad(nvmLoad),
        .nvmComp0(nvmComp0), .nvmComp1(nvmComp1), .comp0(comp0), .comp1(comp1), .loop0(loop0),
        .loop1(loop1), .fbShare(fbShare), .senseGain(senseGain), .phase0(phase0),
        .phase1(phase1), .syncRef(syncRef), .shareClkO(shareClkO), .shareClkOe(shareClkOe));

    // Next pseudo-random word
    function automatic logic [31:0] nextRand(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // Single comparison point, counts everything
    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
        checks_done++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD t=%0t %s: seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    // Verdict and end of run
    task automatic wrap_up();
        $display("Checks %0d, mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // Note the expected answer, send the request, wait a bounded time for it
    task automatic req(input logic wr, input logic [7:0] code, input logic [7:0] page,
                       input logic [1:0] cnt, input logic [7:0] data, input logic a,
                       input logic b, input logic [7:0] rd);
        expQ.push_back('{a, ~a, b, rd});
        pcc_host_model_i.send(wr, code, page, cnt, data);
        for (int k = 0; k < 10 && expQ.size() != 0; k++) begin
            @(negedge clk_sys);
        end
        if (expQ.size() != 0) begin
            check(16'h0, 16'h1, "answer missing");
            expQ.delete();
        end
        repeat (3) @(negedge clk_sys);
    endtask

    // Answer watcher: one answer pops one note
    always @(negedge clk_sys) begin
        if (rsp.ack === 1'b1 || rsp.nack === 1'b1) begin
            if (expQ.size() == 0) begin
                check(16'h1, 16'h0, "unexpected answer");
            end else begin
                check(16'(rsp), 16'(expQ.pop_front()), "answer");
            end
        end
        if (syncRef === 1'b1) begin
            syncCount++;
        end
    end

    // Hang guard, ceiling well above the expected run
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            wrap_up();
        end
    end

    // Main sequence
    initial begin
        repeat (20) @(posedge clk_sys);
        @(negedge clk_sys);
        rst        <= 1'b0;
        vinApplied <= 1'b1;
        repeat (5) @(negedge clk_sys);
        check(16'(comp0), 16'h0070, "comp0 reset");
        check(16'(comp1), 16'h0070, "comp1 reset");
        check(16'(loop0.gm), 16'(gmTab[3]), "gm reset");
        check(16'({fbShare, senseGain}), 16'h0002, "share/gain reset");
        check(16'(phase1), 16'(ph1Tab[0]), "phase reset");
        check(16'(shareClkOe), 16'h0001, "held before start level");
        req(0, PCC_CMD_CONFIG, 8'h01, 2'h1, 8'h00, 1, 0, PCC_CONFIG_RESET);
        $display("Reset values done");
        // Shared clock line gating
        vinAboveOn <= 1'b1;
        repeat (3) @(negedge clk_sys);
        check(16'(shareClkOe), 16'h0000, "released above start");
        vinAboveOn  <= 1'b0;
        vinBelowOff <= 1'b1;
        repeat (3) @(negedge clk_sys);
        check(16'({shareClkO, shareClkOe}), 16'h0001, "pulled low below stop");
        vinBelowOff <= 1'b0;
        req(1, PCC_CMD_CONFIG, 8'h00, 2'h1, 8'h00, 1, 0, 8'h00);
        check(16'(shareClkOe), 16'h0000, "released, gating off");
        $display("Shared clock done");
        // Whole decode table, page 0
        for (int i = 0; i < 32; i++) begin
            d = {3'(i), 5'(i)};
            req(1, PCC_CMD_COMP, 8'h00, 2'h1, d, 1, 0, 8'h00);
            check(16'(loop0.gm), 16'(gmTab[i % 8]), "gm decode");
            check(16'(loop0.res), 16'(resTab[i]), "res decode");
        end
        // Random bytes per page, both pages at once, reads
        lfsr = nextRand(lfsr);
        req(1, PCC_CMD_COMP, 8'h01, 2'h1, lfsr[7:0], 1, 0, 8'h00);
        req(0, PCC_CMD_COMP, 8'h01, 2'h1, 8'h00, 1, 0, lfsr[7:0]);
        req(0, PCC_CMD_COMP, 8'h00, 2'h1, 8'h00, 1, 0, 8'hff);
        check(16'(loop1.gm), 16'(gmTab[lfsr[7:5]]), "gm page 1");
        check(16'(loop1.res), 16'(resTab[lfsr[4:0]]), "res page 1");
        lfsr = nextRand(lfsr);
        req(1, PCC_CMD_COMP, PCC_PAGE_ALL, 2'h1, lfsr[7:0], 1, 0, 8'h00);
        check(16'({comp0, comp1}), 16'({lfsr[7:0], lfsr[7:0]}), "both pages");
        // Byte counts other than one and unknown codes are refused
        req(1, PCC_CMD_COMP, 8'h00, 2'h2, 8'h00, 0, 0, 8'h00);
        req(1, PCC_CMD_COMP, 8'h00, 2'h0, 8'h00, 0, 0, 8'h00);
        req(1, 8'h00, 8'h00, 2'h1, 8'h00, 0, 0, 8'h00);
        check(16'(comp0), 16'(lfsr[7:0]), "refused writes keep");
        $display("Compensation done");
        // Phase, gain and sharing codes; host never asks for gain 11b
        for (int i = 0; i < 5; i++) begin
            d = {1'(i), 2'(i % 3), 1'b1, 1'b0, 3'(i)};
            req(1, PCC_CMD_CONFIG, 8'h00, 2'h1, d, 1, 0, 8'h00);
            check(16'(fbShare), 16'(i % 2), "feedback sharing");
            check(16'(senseGain), 16'(gainTab[i % 3]), "sense gain");
            check(16'({phase0, phase1}), 16'({9'(ph0Tab[i]), 9'(ph1Tab[i])}), "phases");
            check(16'(phase0), 16'(ph0Tab[i]), "phase ch0");
            check(16'(phase1), 16'(ph1Tab[i]), "phase ch1");
        end
        req(1, PCC_CMD_CONFIG, 8'h00, 2'h1, 8'h35, 1, 0, 8'h00);
        check(16'(phase1), 16'(ph1Tab[4]), "reserved phase keeps");
        check(16'(senseGain), 16'h0004, "gain with reserved phase");
        req(0, PCC_CMD_CONFIG, 8'h00, 2'h1, 8'h00, 1, 0, 8'h35);
        // Running channels refuse, powered off accepts
        run0Pin <= 1'b1;
        cmdOn0  <= 1'b1;
        repeat (4) @(negedge clk_sys);
        req(1, PCC_CMD_CONFIG, 8'h00, 2'h1, 8'h10, 0, 1, 8'h00);
        req(0, PCC_CMD_CONFIG, 8'h00, 2'h1, 8'h00, 1, 0, 8'h35);
        cmdOn0 <= 1'b0;
        req(1, PCC_CMD_CONFIG, 8'h00, 2'h1, 8'h11, 1, 0, 8'h00);
        check(16'(phase0), 16'(ph0Tab[1]), "accepted commanded off");
        {run0Pin, run1Pin, cmdOn1} <= 3'b011;
        repeat (4) @(negedge clk_sys);
        req(1, PCC_CMD_CONFIG, 8'h00, 2'h1, 8'h12, 0, 1, 8'h00);
        run1Pin <= 1'b0;
        repeat (4) @(negedge clk_sys);
        req(1, PCC_CMD_CONFIG, 8'h00, 2'h1, 8'h12, 1, 0, 8'h00);
        cmdOn1 <= 1'b0;
        $display("Phase and sense done");
        // Sync reference on falling edge only
        syncPin <= 1'b0;
        repeat (8) @(negedge clk_sys);
        check(16'(syncCount), 16'h0001, "falling edge seen");
        syncPin <= 1'b1;
        repeat (8) @(negedge clk_sys);
        check(16'(syncCount), 16'h0001, "rising edge ignored");
        // Restore of stored compensation
        lfsr = nextRand(lfsr);
        {nvmComp0, nvmComp1} <= lfsr[15:0];
        nvmLoad <= 1'b1;
        @(negedge clk_sys);
        nvmLoad <= 1'b0;
        repeat (3) @(negedge clk_sys);
        check(16'({comp0, comp1}), lfsr[15:0], "restored");
        $display("Sync and restore done");
        wrap_up();
    end
endmodule
`default_nettype wire
